// *** bcnr_pkg.sv ***
package bcnr_pkg;
	// ascii codes the block looks at
	localparam logic [7:0] CH_SPACE = 8'h20;
	localparam logic [7:0] CH_LF = 8'h0A;
	localparam logic [7:0] CH_PLUS = 8'h2B;
	localparam logic [7:0] CH_MINUS = 8'h2D;
	localparam logic [7:0] CH_POINT = 8'h2E;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [7:0] CH_NINE = 8'h39;
	localparam logic [7:0] CH_EXP = 8'h45;
	localparam logic [7:0] CH_CR = 8'h0D;
	// bus address group offsets
	localparam logic [7:0] LISTEN_BASE = 8'h20;
	localparam logic [7:0] TALK_BASE = 8'h40;
	localparam logic [7:0] UNLISTEN = 8'h3F;
	localparam logic [7:0] UNTALK = 8'h5F;
	// stack and address list sizes
	localparam int STACK_DEPTH = 4;
	localparam int ADDR_SLOTS = 5;
	localparam int VAL_CHARS = 24;
	localparam logic [4:0] VAL_LAST = 5'h17;
	localparam logic [2:0] ADDR_LAST = 3'h4;
	// keyboard states
	typedef enum logic [1:0] {BCNR_KB_UNSHIFT, BCNR_KB_SHIFT, BCNR_KB_TAB} bcnr_kb_t;
	// one key event from the keypad side
	typedef struct packed {
		logic sep; // section separator
		logic alpha; // text-entry key, ends command mode
		logic shift; // shift state key
		logic tab; // tab state key
		logic print; // send current value
		logic [5:0] code; // key position
	} bcnr_key_t;
	// one byte on the instrument bus
	typedef struct packed {
		logic [7:0] data;
		logic atn;
		logic eoi;
	} bcnr_byte_t;
	// a parsed value as ascii text, left justified, space filled
	typedef struct packed {
		logic [VAL_CHARS*8-1:0] text;
	} bcnr_val_t;
endpackage

// *** bcnr_handshake.sv ***
`timescale 1ns/10ps
`default_nettype none
// three-wire source handshake for one byte
module bcnr_handshake (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic send_in, // pulse: byte on byte_in is to go
	input wire bcnr_pkg::bcnr_byte_t byte_in,
	input wire logic nrfd_in, // some listener not ready
	input wire logic ndac_in, // some listener has not accepted
	output bcnr_pkg::bcnr_byte_t bus_out,
	output logic dav_out,
	output logic busy_out,
	output logic done_out
);
	typedef enum logic [1:0] {BCNR_HS_IDLE, BCNR_HS_READY, BCNR_HS_VALID} bcnr_hs_t;
	bcnr_hs_t state_r;
	// handshake sequence; next byte waits for every acceptance
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_r <= BCNR_HS_IDLE;
			bus_out <= '0;
			dav_out <= 1'b0;
			done_out <= 1'b0;
		end else begin
			done_out <= 1'b0;
			unique case (state_r)
				BCNR_HS_IDLE: begin
					if (send_in) begin
						bus_out <= byte_in;
						state_r <= BCNR_HS_READY;
					end
				end
				BCNR_HS_READY: begin
					// data settles one cycle before valid is raised
					if (!nrfd_in) begin
						dav_out <= 1'b1;
						state_r <= BCNR_HS_VALID;
					end
				end
				BCNR_HS_VALID: begin
					if (!ndac_in) begin
						dav_out <= 1'b0;
						done_out <= 1'b1;
						state_r <= BCNR_HS_IDLE;
					end
				end
			endcase
		end
	end
	// busy from state only; folding send_in back in would loop through the caller
	assign busy_out = state_r != BCNR_HS_IDLE;

	property p_hold_valid;
		@(posedge clock_in) disable iff (!rst_n_in)
		dav_out && ndac_in |=> dav_out;
	endproperty
	a_hold_valid: assert property (p_hold_valid) else $error("valid dropped early");
	property p_valid_after_ready;
		@(posedge clock_in) disable iff (!rst_n_in)
		$rose(dav_out) |-> !$past(nrfd_in);
	endproperty
	a_valid_after_ready: assert property (p_valid_after_ready) else $error("valid while not ready");
endmodule
`default_nettype wire

// *** bcnr_core.sv ***
`timescale 1ns/10ps
`default_nettype none
// Function
// - first command section bytes carry attention
// - separator drops attention, then keys send data
// - auto address both sections; zero disables
// - three keyboard states, toggle or switch
// - each command starts unshifted
// - print sends value without CR LF
// - parser takes sign, digits, point, exponent
// - positive selector talks that address; zero none
// - skip non-numeric before first digit
// - bus read pushes value on delimiter
// - stack keeps four most recent values
// - spaces skipped, line feed ends read
// - end-or-identify ends the read
// - negative selector reads memory from byte
// - memory read ends after one value
// - address code holds up to five pairs
module bcnr_core (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic cmd_start_in, // pulse: begin command instruction
	input wire logic [39:0] addr_code_in, // five bcd digit pairs, zero = none
	input wire logic key_valid_in, // pulse: key event
	input wire bcnr_pkg::bcnr_key_t key_in,
	input wire logic [7:0] key_char_in, // character looked up for key and state
	input wire bcnr_pkg::bcnr_val_t cur_val_in, // current value text for print
	input wire logic read_start_in, // pulse: begin numeric read
	input wire logic [7:0] selector_in, // signed: + talker, 0 none, - register
	input wire logic [7:0] byte_num_in, // memory start byte
	input wire logic rx_valid_in, // pulse: byte received from talker
	input wire bcnr_pkg::bcnr_byte_t rx_in,
	output logic [15:0] mem_addr_out, // register and byte for memory read
	output logic mem_req_out,
	input wire logic mem_valid_in,
	input wire logic [7:0] mem_data_in,
	input wire logic nrfd_in,
	input wire logic ndac_in,
	output bcnr_pkg::bcnr_byte_t bus_out,
	output logic dav_out,
	output logic rx_ready_out, // we accept the talker's byte
	output bcnr_pkg::bcnr_kb_t kb_state_out,
	output logic cmd_active_out,
	output logic read_active_out,
	output bcnr_pkg::bcnr_val_t stack_out [bcnr_pkg::STACK_DEPTH]
);
	typedef enum logic [2:0] {
		BCNR_IDLE, BCNR_ADDR, BCNR_CMD, BCNR_PRINT, BCNR_TALK, BCNR_READ, BCNR_UNADDR
	} bcnr_st_t;
	bcnr_st_t state_r;
	logic data_sec_r; // second section: attention off
	logic is_read_r; // instruction being run is a read
	logic from_mem_r; // read source is memory
	logic [2:0] slot_r; // address pair being sent
	logic [4:0] pidx_r; // print character index
	logic [39:0] codes_r;
	bcnr_pkg::bcnr_kb_t kb_r;
	bcnr_pkg::bcnr_val_t acc_r; // value being parsed
	logic [4:0] acc_len_r;
	logic in_val_r; // a digit has been seen
	logic send;
	bcnr_pkg::bcnr_byte_t tx;
	logic hs_busy, hs_done;
	logic [55:0] slot_codes; // address pairs padded by an empty pair each side
	bcnr_pkg::bcnr_val_t push_val; // value handed to the stack, eoi byte included
	localparam logic [2:0] ADDR_SLOTS_L = bcnr_pkg::ADDR_LAST;

	// bcd digit pair to bus address number
	function automatic logic [7:0] pair_to_addr(input logic [7:0] p);
		pair_to_addr = {4'h0, p[7:4]} * 8'h0A + {4'h0, p[3:0]};
	endfunction
	// numeric character class
	function automatic logic is_num(input logic [7:0] c);
		is_num = (c >= bcnr_pkg::CH_ZERO && c <= bcnr_pkg::CH_NINE) ||
			c == bcnr_pkg::CH_PLUS || c == bcnr_pkg::CH_MINUS ||
			c == bcnr_pkg::CH_POINT || c == bcnr_pkg::CH_EXP;
	endfunction
	function automatic logic is_digit(input logic [7:0] c);
		is_digit = c >= bcnr_pkg::CH_ZERO && c <= bcnr_pkg::CH_NINE;
	endfunction

	logic [7:0] in_ch;
	logic in_eoi, in_fire;
	assign in_ch = from_mem_r ? mem_data_in : rx_in.data;
	assign in_eoi = !from_mem_r && rx_in.eoi;
	assign in_fire = state_r == BCNR_READ && (from_mem_r ? mem_valid_in : rx_valid_in);
	assign rx_ready_out = state_r == BCNR_READ && !from_mem_r;
	assign mem_req_out = state_r == BCNR_READ && from_mem_r;
	assign cmd_active_out = state_r inside {BCNR_ADDR, BCNR_CMD, BCNR_PRINT} ||
		(state_r == BCNR_UNADDR && !is_read_r);
	assign read_active_out = state_r inside {BCNR_TALK, BCNR_READ} ||
		(state_r == BCNR_UNADDR && is_read_r);
	assign kb_state_out = kb_r;
	// slot 0 reads the empty pad, slot n reads pair n-1, all in range
	assign slot_codes = {8'h00, codes_r, 8'h00};

	// value ends: delimiter after digits, line feed, or eoi
	logic push_now, end_now, delim;
	assign delim = in_fire && !is_num(in_ch) && in_ch != bcnr_pkg::CH_SPACE;
	assign push_now = in_fire && (in_val_r || (in_eoi && is_digit(in_ch))) &&
		(delim || in_ch == bcnr_pkg::CH_LF || in_eoi);
	assign end_now = in_fire && (in_ch == bcnr_pkg::CH_LF || in_eoi ||
		(from_mem_r && delim && in_val_r));

	// eoi rides on the last character, so that character joins the value
	always_comb begin
		push_val = acc_r;
		if (in_eoi && is_num(in_ch) && acc_len_r != bcnr_pkg::VAL_LAST + 5'h1)
			push_val.text[bcnr_pkg::VAL_CHARS*8-1 - 8*acc_len_r -: 8] = in_ch;
	end

	// outgoing byte choice, registered inside the handshake
	always_comb begin
		send = 1'b0;
		tx = '0;
		unique case (state_r)
			BCNR_ADDR: begin
				send = !hs_busy;
				tx.atn = 1'b1;
				tx.data = slot_r == 3'h0 ? bcnr_pkg::UNLISTEN :
					bcnr_pkg::LISTEN_BASE + pair_to_addr(slot_codes[55 - 8*slot_r -: 8]);
			end
			BCNR_CMD: begin
				send = !hs_busy && key_valid_in && !key_in.sep && !key_in.alpha &&
					!key_in.shift && !key_in.tab && !key_in.print;
				tx.atn = !data_sec_r;
				tx.data = key_char_in;
			end
			BCNR_PRINT: begin
				send = !hs_busy;
				tx.data = cur_val_in.text[bcnr_pkg::VAL_CHARS*8-1 - 8*pidx_r -: 8];
			end
			BCNR_TALK: begin
				send = !hs_busy;
				tx.atn = 1'b1;
				tx.data = bcnr_pkg::TALK_BASE + selector_in;
			end
			BCNR_UNADDR: begin
				send = !hs_busy;
				tx.atn = 1'b1;
				tx.data = is_read_r ? bcnr_pkg::UNTALK : bcnr_pkg::UNLISTEN;
			end
			default: ;
		endcase
	end

	bcnr_handshake u_hs (
		.clock_in(clock_in),
		.rst_n_in(rst_n_in),
		.send_in(send),
		.byte_in(tx),
		.nrfd_in(nrfd_in),
		.ndac_in(ndac_in),
		.bus_out(bus_out),
		.dav_out(dav_out),
		.busy_out(hs_busy),
		.done_out(hs_done)
	);

	// instruction sequencing
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_r <= BCNR_IDLE;
			data_sec_r <= 1'b0;
			is_read_r <= 1'b0;
			from_mem_r <= 1'b0;
			slot_r <= '0;
			pidx_r <= '0;
			codes_r <= '0;
			mem_addr_out <= '0;
		end else begin
			unique case (state_r)
				BCNR_IDLE: begin
					if (cmd_start_in) begin
						is_read_r <= 1'b0;
						data_sec_r <= 1'b0;
						codes_r <= addr_code_in;
						slot_r <= '0;
						// zero code: no addressing at all
						state_r <= addr_code_in == '0 ? BCNR_CMD : BCNR_ADDR;
					end else if (read_start_in) begin
						is_read_r <= 1'b1;
						from_mem_r <= selector_in[7];
						mem_addr_out <= {8'(-selector_in), byte_num_in};
						// zero selector: assume controller made us listener
						state_r <= selector_in[7] || selector_in == '0 ? BCNR_READ :
							BCNR_TALK;
					end
				end
				BCNR_ADDR: begin
					// unlisten, then each pair up to the first zero pair as a listener
					if (send) begin
						if (slot_r == ADDR_SLOTS_L + 3'h1 || slot_codes[47 - 8*slot_r -: 8] == '0)
							state_r <= BCNR_CMD;
						slot_r <= slot_r + 3'h1;
					end
				end
				BCNR_CMD: begin
					if (key_valid_in && key_in.sep)
						data_sec_r <= 1'b1;
					if (key_valid_in && key_in.print && data_sec_r) begin
						pidx_r <= '0;
						state_r <= BCNR_PRINT;
					end
					if (key_valid_in && key_in.alpha)
						state_r <= codes_r == '0 ? BCNR_IDLE : BCNR_UNADDR;
				end
				BCNR_PRINT: begin
					// cr lf never sent; all 24 characters of the field are sent, trailing fill spaces included
					if (send) begin
						pidx_r <= pidx_r + 5'h1;
						if (pidx_r == bcnr_pkg::VAL_LAST)
							state_r <= BCNR_CMD;
					end
				end
				BCNR_TALK: begin
					if (send)
						state_r <= BCNR_READ;
				end
				BCNR_READ: begin
					if (from_mem_r && mem_valid_in)
						mem_addr_out[7:0] <= mem_addr_out[7:0] + 8'h01;
					if (end_now)
						state_r <= from_mem_r || selector_in == '0 ? BCNR_IDLE :
							BCNR_UNADDR;
				end
				BCNR_UNADDR: begin
					if (send)
						state_r <= BCNR_IDLE;
				end
			endcase
		end
	end
	// keyboard state machine
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			kb_r <= bcnr_pkg::BCNR_KB_UNSHIFT;
		end else if (cmd_start_in && state_r == BCNR_IDLE) begin
			kb_r <= bcnr_pkg::BCNR_KB_UNSHIFT;
		end else if (state_r == BCNR_CMD && key_valid_in) begin
			if (key_in.shift)
				kb_r <= kb_r == bcnr_pkg::BCNR_KB_SHIFT ? bcnr_pkg::BCNR_KB_UNSHIFT :
					bcnr_pkg::BCNR_KB_SHIFT;
			else if (key_in.tab)
				kb_r <= kb_r == bcnr_pkg::BCNR_KB_TAB ? bcnr_pkg::BCNR_KB_UNSHIFT :
					bcnr_pkg::BCNR_KB_TAB;
		end
	end

	// value accumulation; text kept left justified, spaces fill
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			acc_r <= '0;
			acc_len_r <= '0;
			in_val_r <= 1'b0;
		end else if (state_r != BCNR_READ || push_now) begin
			acc_r.text <= {bcnr_pkg::VAL_CHARS{bcnr_pkg::CH_SPACE}};
			acc_len_r <= '0;
			in_val_r <= 1'b0;
		end else if (in_fire && is_num(in_ch)) begin
			// sign, point or exponent before digits is kept; others before a digit dropped
			if (acc_len_r != bcnr_pkg::VAL_LAST + 5'h1) begin
				acc_r.text[bcnr_pkg::VAL_CHARS*8-1 - 8*acc_len_r -: 8] <= in_ch;
				acc_len_r <= acc_len_r + 5'h1;
			end
			if (is_digit(in_ch))
				in_val_r <= 1'b1;
		end else if (in_fire && !in_val_r && in_ch != bcnr_pkg::CH_SPACE) begin
			// junk before a value clears any stray sign
			acc_r.text <= {bcnr_pkg::VAL_CHARS{bcnr_pkg::CH_SPACE}};
			acc_len_r <= '0;
		end
	end

	// four-level stack, push at bottom, top falls off
	generate
		for (genvar i = 0; i < bcnr_pkg::STACK_DEPTH; i++) begin : g_stk
			if (i == 0) begin : g_bot
				// bottom entry takes the finished value
				always_ff @(posedge clock_in or negedge rst_n_in) begin
					if (!rst_n_in)
						stack_out[i] <= '0;
					else if (push_now)
						stack_out[i] <= push_val;
				end
			end else begin : g_up
				// older entries move up; the top one is lost
				always_ff @(posedge clock_in or negedge rst_n_in) begin
					if (!rst_n_in)
						stack_out[i] <= '0;
					else if (push_now)
						stack_out[i] <= stack_out[i-1];
				end
			end
		end
	endgenerate

	property p_kb_reset;
		@(posedge clock_in) disable iff (!rst_n_in)
		(cmd_start_in && state_r == BCNR_IDLE) |=> kb_r == bcnr_pkg::BCNR_KB_UNSHIFT;
	endproperty
	a_kb_reset: assert property (p_kb_reset) else $error("keyboard not unshifted");
	property p_shift_toggle;
		@(posedge clock_in) disable iff (!rst_n_in)
		(state_r == BCNR_CMD && key_valid_in && key_in.shift && !cmd_start_in &&
			kb_r == bcnr_pkg::BCNR_KB_SHIFT) |=> kb_r == bcnr_pkg::BCNR_KB_UNSHIFT;
	endproperty
	a_shift_toggle: assert property (p_shift_toggle) else $error("shift not cancelled");
	property p_tab_direct;
		@(posedge clock_in) disable iff (!rst_n_in)
		(state_r == BCNR_CMD && key_valid_in && key_in.tab && !key_in.shift &&
			kb_r == bcnr_pkg::BCNR_KB_SHIFT) |=> kb_r == bcnr_pkg::BCNR_KB_TAB;
	endproperty
	a_tab_direct: assert property (p_tab_direct) else $error("no direct switch");
	property p_atn_first;
		@(posedge clock_in) disable iff (!rst_n_in)
		(send && state_r == BCNR_CMD && !data_sec_r) |=> bus_out.atn;
	endproperty
	a_atn_first: assert property (p_atn_first) else $error("command byte without atn");
	property p_data_no_atn;
		@(posedge clock_in) disable iff (!rst_n_in)
		(send && state_r inside {BCNR_PRINT} ) |=> !bus_out.atn;
	endproperty
	a_data_no_atn: assert property (p_data_no_atn) else $error("data with atn");
	property p_zero_code;
		@(posedge clock_in) disable iff (!rst_n_in)
		(state_r == BCNR_IDLE && cmd_start_in && addr_code_in == '0) |=> state_r == BCNR_CMD;
	endproperty
	a_zero_code: assert property (p_zero_code) else $error("addressing not suppressed");
	property p_lf_ends;
		@(posedge clock_in) disable iff (!rst_n_in)
		(in_fire && in_ch == bcnr_pkg::CH_LF) |=> state_r != BCNR_READ;
	endproperty
	a_lf_ends: assert property (p_lf_ends) else $error("line feed did not end read");
	property p_eoi_ends;
		@(posedge clock_in) disable iff (!rst_n_in)
		(in_fire && in_eoi) |=> state_r != BCNR_READ;
	endproperty
	a_eoi_ends: assert property (p_eoi_ends) else $error("eoi did not end read");
	property p_push_shift;
		@(posedge clock_in) disable iff (!rst_n_in)
		push_now |=> stack_out[3] == $past(stack_out[2]) && stack_out[0] == $past(push_val);
	endproperty
	a_push_shift: assert property (p_push_shift) else $error("stack did not shift");
	property p_done_after_valid;
		@(posedge clock_in) disable iff (!rst_n_in)
		hs_done |-> !dav_out && $past(dav_out);
	endproperty
	a_done_after_valid: assert property (p_done_after_valid) else $error("byte done without valid");
endmodule
`default_nettype wire

// *** bcnr_instr_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// bus instruments: one listener on the handshake plus one talker
module bcnr_instr_model (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire bcnr_pkg::bcnr_byte_t bus_in,
	input wire logic dav_in,
	input wire logic rx_ready_in, // block is reading from us
	input wire logic [3:0] lag_in, // extra cycles before accepting
	output logic nrfd_out,
	output logic ndac_out,
	output logic rx_valid_out,
	output bcnr_pkg::bcnr_byte_t rx_out
);
	bcnr_pkg::bcnr_byte_t got_q [$]; // every byte accepted, in order
	logic [3:0] wait_r; // slow listener delay count
	// talker lines start released
	initial begin
		rx_valid_out = 1'b0;
		rx_out = '1;
	end
	// listener: accept only while dav stands, let go once dav drops
	always @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			nrfd_out <= 1'b0;
			ndac_out <= 1'b1;
			wait_r <= 4'h0;
		end else if (dav_in && ndac_out) begin
			nrfd_out <= 1'b1;
			if (wait_r == lag_in) begin
				ndac_out <= 1'b0;
				got_q.push_back(bus_in);
				wait_r <= 4'h0;
			end else begin
				wait_r <= wait_r + 4'h1;
			end
		end else if (!dav_in) begin
			// ready again only after the source withdrew dav
			ndac_out <= 1'b1;
			nrfd_out <= 1'b0;
		end
	end
	// talker: one byte per ready slot, eoi only on the final one
	task automatic talk(input string s, input logic eoi_last);
		int i;
		int n;
		for (i = 0; i < s.len(); i++) begin
			@(posedge clock_in);
			n = 0;
			while (rx_ready_in !== 1'b1 && n < 100) begin
				@(posedge clock_in);
				n++;
			end
			rx_out <= {s[i], 1'b0, eoi_last && (i == s.len() - 1)};
			rx_valid_out <= 1'b1;
			@(posedge clock_in);
			rx_valid_out <= 1'b0;
			// released lines never show the stale byte
			rx_out <= ~{s[i], 2'b00};
		end
	endtask
endmodule
`default_nettype wire

// *** tb_bus_command_and_numeric_reader.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_bus_command_and_numeric_reader;
	logic clock_in, rst_n_in, cmd_start_in, key_valid_in, read_start_in, mem_req_out;
	logic [39:0] addr_code_in;
	bcnr_pkg::bcnr_key_t key_in;
	logic [7:0] key_char_in, selector_in, byte_num_in, mem_data_in;
	bcnr_pkg::bcnr_val_t cur_val_in;
	logic rx_valid_in, mem_valid_in, nrfd_in, ndac_in, dav_out, rx_ready_out;
	bcnr_pkg::bcnr_byte_t rx_in, bus_out, bus_prev;
	logic [15:0] mem_addr_out, first_addr;
	bcnr_pkg::bcnr_kb_t kb_state_out;
	logic cmd_active_out, read_active_out, dav_prev, seen_addr;
	bcnr_pkg::bcnr_val_t stack_out [bcnr_pkg::STACK_DEPTH];
	logic [3:0] lag; // partner slowness
	logic [7:0] mem [256]; // byte memory for negative selectors
	int n_fail, n_checks, i;
	logic [47:0] mem_txt; // text placed in memory for the memory read
	logic [4:0] kb_key [4]; // state key table: sep alpha shift tab print
	logic [1:0] kb_exp [4];
	bcnr_core dut_u (.clock_in(clock_in), .rst_n_in(rst_n_in), .cmd_start_in(cmd_start_in),
		.addr_code_in(addr_code_in), .key_valid_in(key_valid_in), .key_in(key_in),
		.key_char_in(key_char_in), .cur_val_in(cur_val_in), .read_start_in(read_start_in),
		.selector_in(selector_in), .byte_num_in(byte_num_in), .rx_valid_in(rx_valid_in),
		.rx_in(rx_in), .mem_addr_out(mem_addr_out), .mem_req_out(mem_req_out),
		.mem_valid_in(mem_valid_in), .mem_data_in(mem_data_in), .nrfd_in(nrfd_in),
		.ndac_in(ndac_in), .bus_out(bus_out), .dav_out(dav_out), .rx_ready_out(rx_ready_out),
		.kb_state_out(kb_state_out), .cmd_active_out(cmd_active_out),
		.read_active_out(read_active_out), .stack_out(stack_out));
	bcnr_instr_model ins_u (.clock_in(clock_in), .rst_n_in(rst_n_in), .bus_in(bus_out),
		.dav_in(dav_out), .rx_ready_in(rx_ready_out), .lag_in(lag), .nrfd_out(nrfd_in),
		.ndac_out(ndac_in), .rx_valid_out(rx_valid_in), .rx_out(rx_in));
	// 10 MHz clock
	initial begin
		clock_in = 1'b0;
		forever #50 clock_in = ~clock_in;
	end
	// verdict and end of run, shared with the watchdog
	task automatic complete_run();
		if (n_fail == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t value %h expected %h", $time, got, exp);
		end
	endtask
	// n-th byte seen by the listener
	task automatic chk_byte(input int idx, input bcnr_pkg::bcnr_byte_t exp);
		bcnr_pkg::bcnr_byte_t got;
		got = (idx < ins_u.got_q.size()) ? ins_u.got_q[idx] : 'x;
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t bus byte %0d is %h expected %h", $time, idx, got, exp);
		end
	endtask
	task automatic chk_val(input bcnr_pkg::bcnr_val_t got, input string s);
		bcnr_pkg::bcnr_val_t exp;
		exp.text = {bcnr_pkg::VAL_CHARS{bcnr_pkg::CH_SPACE}};
		for (int k = 0; k < s.len(); k++) exp.text[bcnr_pkg::VAL_CHARS*8-1-8*k -: 8] = s[k];
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t stack entry differs from %s", $time, s);
		end
	endtask
	// one key event, then room for the state update
	task automatic press(input logic [4:0] flags, input logic [7:0] ch);
		@(posedge clock_in);
		key_in <= {flags, 6'h00};
		key_char_in <= ch;
		key_valid_in <= 1'b1;
		@(posedge clock_in);
		key_valid_in <= 1'b0;
		repeat (3) @(posedge clock_in);
	endtask
	task automatic start_cmd(input logic [39:0] code);
		@(posedge clock_in);
		addr_code_in <= code;
		cmd_start_in <= 1'b1;
		@(posedge clock_in);
		cmd_start_in <= 1'b0;
	endtask
	task automatic start_read(input logic [7:0] sel, input logic [7:0] bn);
		@(posedge clock_in);
		selector_in <= sel;
		byte_num_in <= bn;
		read_start_in <= 1'b1;
		@(posedge clock_in);
		read_start_in <= 1'b0;
	endtask
	// bounded wait for the listener count, then let the handshake settle
	task automatic wait_bytes(input int n);
		int k;
		k = 0;
		while (ins_u.got_q.size() < n && k < 400) begin
			@(posedge clock_in);
			k++;
		end
		if (k == 400) begin
			n_fail++;
			$display("BAD %0t bus bytes did not arrive", $time);
		end
		repeat (4) @(posedge clock_in);
		@(negedge clock_in);
	endtask
	task automatic wait_end();
		int k;
		k = 0;
		// let the start edge take effect before looking
		@(posedge clock_in);
		while (read_active_out !== 1'b0 && k < 500) begin
			@(posedge clock_in);
			k++;
		end
		if (k == 500) begin
			n_fail++;
			$display("BAD %0t read did not end", $time);
		end
		@(negedge clock_in);
	endtask
	// memory answers every other request cycle; first address kept for checking
	always @(posedge clock_in) begin
		if (rst_n_in !== 1'b1) begin
			mem_valid_in <= 1'b0;
			mem_data_in <= 8'h00;
			seen_addr <= 1'b0;
			first_addr <= '0;
		end else begin
			mem_valid_in <= mem_req_out && !mem_valid_in;
			mem_data_in <= mem[mem_addr_out[7:0]];
			if (mem_req_out === 1'b1 && !seen_addr) begin
				first_addr <= mem_addr_out;
				seen_addr <= 1'b1;
			end
		end
	end
	// a byte on the bus may not move while dav stands
	always @(posedge clock_in) begin
		if (dav_out === 1'b1 && dav_prev === 1'b1) chk8(8'(bus_out !== bus_prev), 8'h00);
		dav_prev <= dav_out;
		bus_prev <= bus_out;
	end
	// cut a hang short; the tests take a few hundred cycles
	initial begin
		repeat (20000) @(posedge clock_in);
		n_fail++;
		complete_run();
	end
	initial begin
		{cmd_start_in, key_valid_in, read_start_in} = '0;
		{addr_code_in, key_char_in, selector_in, byte_num_in} = '0;
		key_in = '0;
		n_fail = 0;
		n_checks = 0;
		lag = 4'h3;
		rst_n_in = 1'b0;
		cur_val_in.text = {"-1.25", {19{8'h20}}};
		for (i = 0; i < 256; i++) mem[i] = 8'h21;
		mem_txt = "q 25x9";
		for (i = 0; i < 6; i++) mem[5 + i] = mem_txt[8*(5-i) +: 8];
		kb_key = '{5'b00100, 5'b00010, 5'b00010, 5'b00100};
		kb_exp = '{bcnr_pkg::BCNR_KB_SHIFT, bcnr_pkg::BCNR_KB_TAB, bcnr_pkg::BCNR_KB_UNSHIFT,
			bcnr_pkg::BCNR_KB_SHIFT};
		repeat (2) @(posedge clock_in);
		rst_n_in <= 1'b1;
		@(negedge clock_in);
		chk8({4'h0, kb_state_out, cmd_active_out, read_active_out}, 8'h00);
		chk8(8'(stack_out[0].text !== '0), 8'h00);
		// command with two listeners, slow partner
		start_cmd(40'h2205000000);
		wait_bytes(3);
		chk_byte(0, {bcnr_pkg::UNLISTEN, 2'b10});
		chk_byte(1, {bcnr_pkg::LISTEN_BASE + 8'h16, 2'b10});
		chk_byte(2, {bcnr_pkg::LISTEN_BASE + 8'h05, 2'b10});
		press(5'b10000, 8'h00);
		press(5'b00000, 8'h52);
		wait_bytes(4);
		chk_byte(3, {8'h52, 2'b00});
		for (i = 0; i < 4; i++) begin
			press(kb_key[i], 8'h00);
			chk8({6'h00, kb_state_out}, {6'h00, kb_exp[i]});
		end
		press(5'b01000, 8'h00);
		wait_bytes(5);
		chk_byte(4, {bcnr_pkg::UNLISTEN, 2'b10});
		chk8({7'h00, cmd_active_out}, 8'h00);
		// no addressing; starts unshifted; print without line end
		lag <= 4'h0;
		start_cmd(40'h0);
		@(negedge clock_in);
		chk8({6'h00, kb_state_out}, {6'h00, bcnr_pkg::BCNR_KB_UNSHIFT});
		press(5'b10000, 8'h00);
		press(5'b00100, 8'h00);
		press(5'b00001, 8'h00);
		wait_bytes(29);
		for (i = 0; i < 24; i++) chk_byte(5 + i, {cur_val_in.text[191-8*i -: 8], 2'b00});
		press(5'b01000, 8'h00);
		// no byte may follow the printed field
		repeat (40) @(posedge clock_in);
		chk8(8'(ins_u.got_q.size()), 8'h1D);
		// bus read: junk, spaces, exponents, overflow of the stack
		start_read(8'h16, 8'h00);
		wait_bytes(30);
		chk_byte(29, {bcnr_pkg::TALK_BASE + 8'h16, 2'b10});
		ins_u.talk("-a12,1.5E+3;4 5,2-4,78,\n", 1'b0);
		wait_end();
		wait_bytes(31);
		chk_byte(30, {bcnr_pkg::UNTALK, 2'b10});
		chk_val(stack_out[0], "78");
		chk_val(stack_out[1], "2-4");
		chk_val(stack_out[2], "45");
		chk_val(stack_out[3], "1.5E+3");
		// memory read from register 3, byte 5
		start_read(8'hFD, 8'h05);
		wait_end();
		chk8(first_addr[15:8], 8'h03);
		chk8(first_addr[7:0], 8'h05);
		chk_val(stack_out[0], "25");
		chk_val(stack_out[1], "78");
		chk_val(stack_out[3], "45");
		chk8(8'(ins_u.got_q.size()), 8'h1F);
		// zero selector read ended by eoi
		start_read(8'h00, 8'h00);
		ins_u.talk("7,8", 1'b1);
		wait_end();
		chk8({7'h00, read_active_out}, 8'h00);
		chk8(8'(ins_u.got_q.size()), 8'h1F);
		chk_val(stack_out[0], "8");
		chk_val(stack_out[1], "7");
		// a key before the separator goes out as a bus message
		start_cmd(40'h0);
		press(5'b00000, 8'h14);
		wait_bytes(32);
		chk_byte(31, {8'h14, 2'b10});
		press(5'b01000, 8'h00);
		complete_run();
	end
endmodule
`default_nettype wire
